/* rtl/pcef_top.sv */
// pin change edge flags: apb registers, edge flags, interrupt
// How it works
// - port b rising edge, enabled, sets flag
// - port b falling edge, enabled, sets flag
// - port c enabled edges set flags
// - port e enabled edges set flags
// - pin g5 enabled edges set flag
// - flag clears by writing zero
// - falling enable arms flag and status
// - disabled edge direction never sets flag
// - reset pin or lvp disables g5
// - port g holds only bit five
// - port e falling enables per pin
// - edges flagged even with interrupt disabled
// - summary is or of all flags
// - edge during clearing write keeps flag
// - rise enables too, both allowed together
// assumes an apb master and pins synchronous to core_clk_i
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
module pcef_top #(
  parameter int unsigned ADDR_W = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // pins
  input wire pcef_pkg::pcef_pins_t pins_i,
  // interrupt and summary
  output logic irq_o,
  output logic summary_o
);
  if (ADDR_W < 15)
  begin
    $error("pcef_top needs ADDR_W of at least 15");
  end

  function automatic logic at_idx(input logic [ADDR_W-1:0] a,
                                  input logic [11:0] idx);
    at_idx = (a == {{(ADDR_W - 14){1'b0}}, idx, 2'b00});
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb phases
  pcef_pkg::pcef_apb_st_t state;
  logic wstb;
  logic map_ok;
  logic [31:0] next_rdata;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state <= pcef_pkg::ST_IDLE;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end
    else
    begin
      unique case (state)
        pcef_pkg::ST_IDLE:
        begin
          if (psel_i && penable_i)
            state <= pcef_pkg::ST_WAIT;
        end
        pcef_pkg::ST_WAIT:
        begin
          state <= pcef_pkg::ST_DONE;
          pready_o <= 1'b1;
          pslverr_o <= ~map_ok;
          prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
        end
        pcef_pkg::ST_DONE:
        begin
          state <= pcef_pkg::ST_IDLE;
          pready_o <= 1'b0;
          pslverr_o <= 1'b0;
        end
        default:
        begin
          state <= pcef_pkg::ST_IDLE;
          pready_o <= 1'b0;
          pslverr_o <= 1'b0;
        end
      endcase
    end
  end

  // write commits on the completing edge, unmapped writes dropped
  assign wstb = (state == pcef_pkg::ST_DONE) && psel_i && penable_i &&
                pwrite_i && map_ok;

  ////////////////////////////////////////////////////////////////////////
  // enable and control registers
  logic [7:0] fall_b;
  logic [7:0] fall_c;
  logic [7:0] fall_e;
  logic fall_g5;
  logic [7:0] rise_b;
  logic [7:0] rise_c;
  logic [7:0] rise_e;
  logic rise_g5;
  logic [pcef_pkg::CFG_W-1:0] cfg;
  logic [pcef_pkg::EV_W-1:0] ev_mask;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      fall_b <= pcef_pkg::RST_PORT;
      fall_c <= pcef_pkg::RST_PORT;
      fall_e <= pcef_pkg::RST_PORT;
      fall_g5 <= pcef_pkg::RST_G5_FALL;
    end
    else if (wstb)
    begin
      if (at_idx(paddr_i, pcef_pkg::IDX_B_FALL))
        fall_b <= pwdata_i[7:0];
      if (at_idx(paddr_i, pcef_pkg::IDX_C_FALL))
        fall_c <= pwdata_i[7:0];
      if (at_idx(paddr_i, pcef_pkg::IDX_E_FALL))
        fall_e <= pwdata_i[7:0];
      if (at_idx(paddr_i, pcef_pkg::IDX_G_FALL))
        fall_g5 <= pwdata_i[pcef_pkg::G5_BIT];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      rise_b <= pcef_pkg::RST_PORT;
      rise_c <= pcef_pkg::RST_PORT;
      rise_e <= pcef_pkg::RST_PORT;
      rise_g5 <= pcef_pkg::RST_G5_RISE;
    end
    else if (wstb)
    begin
      if (at_idx(paddr_i, pcef_pkg::IDX_B_RISE))
        rise_b <= pwdata_i[7:0];
      if (at_idx(paddr_i, pcef_pkg::IDX_C_RISE))
        rise_c <= pwdata_i[7:0];
      if (at_idx(paddr_i, pcef_pkg::IDX_E_RISE))
        rise_e <= pwdata_i[7:0];
      if (at_idx(paddr_i, pcef_pkg::IDX_G_RISE))
        rise_g5 <= pwdata_i[pcef_pkg::G5_BIT];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cfg <= pcef_pkg::RST_CFG;
      ev_mask <= pcef_pkg::RST_EV;
    end
    else if (wstb)
    begin
      if (at_idx(paddr_i, pcef_pkg::IDX_CONFIG))
        cfg <= pwdata_i[pcef_pkg::CFG_W-1:0];
      if (at_idx(paddr_i, pcef_pkg::IDX_EV_MASK))
        ev_mask <= pwdata_i[pcef_pkg::EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // edge detection and qualification
  logic [pcef_pkg::PIN_W-1:0] rise_raw;
  logic [pcef_pkg::PIN_W-1:0] fall_raw;
  logic [pcef_pkg::PIN_W-1:0] rise_en;
  logic [pcef_pkg::PIN_W-1:0] fall_en;
  logic [pcef_pkg::PIN_W-1:0] pin_ok;
  logic [pcef_pkg::PIN_W-1:0] hit;
  logic g5_ok;

  pcef_edge_detect #(
    .W(pcef_pkg::PIN_W)
  ) u_edges (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .level_i(pins_i),
    .rise_o(rise_raw),
    .fall_o(fall_raw)
  );

  // g5 loses its port function under reset pin or lvp
  assign g5_ok = ~(cfg[pcef_pkg::CFG_MCLR] | cfg[pcef_pkg::CFG_LVP]);
  assign pin_ok = {{(pcef_pkg::PIN_W - 1){1'b1}}, g5_ok};
  assign rise_en = {rise_b, rise_c, rise_e, rise_g5};
  assign fall_en = {fall_b, fall_c, fall_e, fall_g5};
  // each direction only through its own enable
  assign hit = ((rise_raw & rise_en) | (fall_raw & fall_en)) & pin_ok;

  ////////////////////////////////////////////////////////////////////////
  // flag banks
  logic [7:0] flag_b;
  logic [7:0] flag_c;
  logic [7:0] flag_e;
  logic [0:0] flag_g;
  logic [7:0] hit_b;
  logic [7:0] hit_c;
  logic [7:0] hit_e;
  logic wr_fb;
  logic wr_fc;
  logic wr_fe;
  logic wr_fg;

  assign hit_b = hit[24:17];
  assign hit_c = hit[16:9];
  assign hit_e = hit[8:1];
  assign wr_fb = wstb && at_idx(paddr_i, pcef_pkg::IDX_B_FLAG);
  assign wr_fc = wstb && at_idx(paddr_i, pcef_pkg::IDX_C_FLAG);
  assign wr_fe = wstb && at_idx(paddr_i, pcef_pkg::IDX_E_FLAG);
  assign wr_fg = wstb && at_idx(paddr_i, pcef_pkg::IDX_G_FLAG);

  pcef_flag_reg #(.W(8)) u_flag_b (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(hit_b),
    .wr_i(wr_fb),
    .wdata_i(pwdata_i[7:0]),
    .flags_o(flag_b)
  );

  pcef_flag_reg #(.W(8)) u_flag_c (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(hit_c),
    .wr_i(wr_fc),
    .wdata_i(pwdata_i[7:0]),
    .flags_o(flag_c)
  );

  pcef_flag_reg #(.W(8)) u_flag_e (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(hit_e),
    .wr_i(wr_fe),
    .wdata_i(pwdata_i[7:0]),
    .flags_o(flag_e)
  );

  pcef_flag_reg #(.W(1)) u_flag_g (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .set_i(hit[0:0]),
    .wr_i(wr_fg),
    .wdata_i(pwdata_i[pcef_pkg::G5_BIT:pcef_pkg::G5_BIT]),
    .flags_o(flag_g)
  );

  ////////////////////////////////////////////////////////////////////////
  // event status, interrupt and summary
  logic [pcef_pkg::EV_W-1:0] ev_stat;
  logic [pcef_pkg::EV_W-1:0] ev_set;
  logic [pcef_pkg::EV_W-1:0] ev_clr;

  assign ev_set = {hit[0], |hit_e, |hit_c, |hit_b};
  assign ev_clr = (wstb && at_idx(paddr_i, pcef_pkg::IDX_EV_STAT)) ?
                  pwdata_i[pcef_pkg::EV_W-1:0] : '0;

  // set beats a write-one clear
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      ev_stat <= pcef_pkg::RST_EV;
    else
      ev_stat <= (ev_stat & ~ev_clr) | ev_set;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      irq_o <= 1'b0;
      summary_o <= 1'b0;
    end
    else
    begin
      irq_o <= (|(ev_stat & ev_mask)) & cfg[pcef_pkg::CFG_IE];
      summary_o <= |{flag_b, flag_c, flag_e, flag_g};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read decode, unimplemented g bits read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    map_ok = 1'b1;
    if (at_idx(paddr_i, pcef_pkg::IDX_B_FLAG))
      next_rdata[7:0] = flag_b;
    else if (at_idx(paddr_i, pcef_pkg::IDX_B_FALL))
      next_rdata[7:0] = fall_b;
    else if (at_idx(paddr_i, pcef_pkg::IDX_B_RISE))
      next_rdata[7:0] = rise_b;
    else if (at_idx(paddr_i, pcef_pkg::IDX_C_FLAG))
      next_rdata[7:0] = flag_c;
    else if (at_idx(paddr_i, pcef_pkg::IDX_C_FALL))
      next_rdata[7:0] = fall_c;
    else if (at_idx(paddr_i, pcef_pkg::IDX_C_RISE))
      next_rdata[7:0] = rise_c;
    else if (at_idx(paddr_i, pcef_pkg::IDX_E_FLAG))
      next_rdata[7:0] = flag_e;
    else if (at_idx(paddr_i, pcef_pkg::IDX_E_FALL))
      next_rdata[7:0] = fall_e;
    else if (at_idx(paddr_i, pcef_pkg::IDX_E_RISE))
      next_rdata[7:0] = rise_e;
    else if (at_idx(paddr_i, pcef_pkg::IDX_G_FLAG))
      next_rdata[pcef_pkg::G5_BIT] = flag_g[0];
    else if (at_idx(paddr_i, pcef_pkg::IDX_G_FALL))
      next_rdata[pcef_pkg::G5_BIT] = fall_g5;
    else if (at_idx(paddr_i, pcef_pkg::IDX_G_RISE))
      next_rdata[pcef_pkg::G5_BIT] = rise_g5;
    else if (at_idx(paddr_i, pcef_pkg::IDX_EV_STAT))
      next_rdata[pcef_pkg::EV_W-1:0] = ev_stat;
    else if (at_idx(paddr_i, pcef_pkg::IDX_EV_MASK))
      next_rdata[pcef_pkg::EV_W-1:0] = ev_mask;
    else if (at_idx(paddr_i, pcef_pkg::IDX_CONFIG))
      next_rdata[pcef_pkg::CFG_W-1:0] = cfg;
    else if (at_idx(paddr_i, pcef_pkg::IDX_SUMMARY))
      next_rdata[0] = |{flag_b, flag_c, flag_e, flag_g};
    else
      map_ok = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_clear_b;
    wr_fb && (pwdata_i[7:0] == 8'h00) && (hit_b == 8'h00);
  endsequence

  sequence s_flags_b_zero;
    flag_b == 8'h00;
  endsequence

  a_b_rise_sets: assert property (
    ((rise_raw[24:17] & rise_b) != 8'h00) |=>
    ((flag_b & $past(rise_raw[24:17] & rise_b)) ==
     $past(rise_raw[24:17] & rise_b)))
    else $error("port b rising edge did not set flag");
  a_b_fall_sets: assert property (
    ((fall_raw[24:17] & fall_b) != 8'h00) |=>
    ((flag_b & $past(fall_raw[24:17] & fall_b)) ==
     $past(fall_raw[24:17] & fall_b)))
    else $error("port b falling edge did not set flag");
  a_c_edge_sets: assert property (
    (hit_c != 8'h00) |=> ((flag_c & $past(hit_c)) == $past(hit_c)))
    else $error("port c edge did not set flag");
  a_e_edge_sets: assert property (
    (hit_e != 8'h00) |=> ((flag_e & $past(hit_e)) == $past(hit_e)))
    else $error("port e edge did not set flag");
  a_g5_edge_sets: assert property (
    (g5_ok && ((rise_raw[0] && rise_g5) || (fall_raw[0] && fall_g5)))
    |=> flag_g[0])
    else $error("g5 edge did not set flag");
  a_flag_clear: assert property (s_clear_b |=> s_flags_b_zero)
    else $error("writing zero did not clear port b flags");
  a_fall_arms: assert property (
    ((fall_raw[8:1] & fall_e) != 8'h00) |=>
    (flag_e != 8'h00) && ev_stat[pcef_pkg::EV_E])
    else $error("armed falling edge missed flag or status");
  a_no_disabled: assert property (
    (!wr_fb && ((rise_raw[24:17] & ~rise_b) != 8'h00) &&
     ((fall_raw[24:17] & fall_b) == 8'h00) &&
     ((rise_raw[24:17] & rise_b) == 8'h00))
    |=> (flag_b == $past(flag_b)))
    else $error("disabled edge changed port b flags");
  a_g5_blocked: assert property (
    (!g5_ok && !wr_fg) |=> (flag_g == $past(flag_g)))
    else $error("g5 flag moved while pin unavailable");
  a_g_bits_zero: assert property (
    (pready_o && !pslverr_o && psel_i && !pwrite_i &&
     at_idx(paddr_i, pcef_pkg::IDX_G_FLAG))
    |-> ((prdata_o & ~32'h0000_0020) == 32'h0000_0000))
    else $error("port g flag read shows unimplemented bits");
  a_e_fall_write: assert property (
    (wstb && at_idx(paddr_i, pcef_pkg::IDX_E_FALL))
    |=> (fall_e == $past(pwdata_i[7:0])))
    else $error("port e falling enable write lost");
  a_ie_gates_irq: assert property (
    (!cfg[pcef_pkg::CFG_IE] && (hit_b != 8'h00))
    |=> !irq_o && (flag_b != 8'h00))
    else $error("interrupt enable clear misbehaved");
  a_summary_or: assert property (
    ##1 (summary_o == $past(|{flag_b, flag_c, flag_e, flag_g})))
    else $error("summary is not the or of all flags");
  a_set_wins: assert property (
    (wr_fb && (hit_b != 8'h00)) |=>
    ((flag_b & $past(hit_b)) == $past(hit_b)))
    else $error("edge lost during clearing write");
  a_both_edges: assert property (
    (((rise_raw[16:9] | fall_raw[16:9]) & rise_c & fall_c) != 8'h00)
    |=> (flag_c != 8'h00))
    else $error("dual enabled pin missed an edge");
  a_edge_source: assert property (
    ##1 ((rise_raw & ~(pins_i & ~$past(pins_i))) == '0) &&
        ((fall_raw & ~(~pins_i & $past(pins_i))) == '0))
    else $error("edge pulse without level change");
  a_no_write_set: assert property (
    (wr_fb && (hit_b == 8'h00)) |=> ((flag_b & ~$past(flag_b)) == 8'h00))
    else $error("write set a port b flag");
endmodule

/* rtl/pcef_pkg.sv */
// pin change edge flag constants, register indices and carrier types
// assumes a 32-bit apb slave and pins synchronous to core_clk_i
package pcef_pkg;
  // register indices, byte address is four times the index
  localparam logic [11:0] IDX_B_FLAG = 12'he93;
  localparam logic [11:0] IDX_B_FALL = 12'he94;
  localparam logic [11:0] IDX_B_RISE = 12'he95;
  localparam logic [11:0] IDX_C_FLAG = 12'he9b;
  localparam logic [11:0] IDX_C_FALL = 12'he9c;
  localparam logic [11:0] IDX_C_RISE = 12'he9d;
  localparam logic [11:0] IDX_E_FLAG = 12'hea8;
  localparam logic [11:0] IDX_E_FALL = 12'hea9;
  localparam logic [11:0] IDX_E_RISE = 12'heaa;
  localparam logic [11:0] IDX_G_FLAG = 12'heb5;
  localparam logic [11:0] IDX_G_FALL = 12'heb6;
  localparam logic [11:0] IDX_G_RISE = 12'heb7;
  localparam logic [11:0] IDX_EV_STAT = 12'hec0;
  localparam logic [11:0] IDX_EV_MASK = 12'hec1;
  localparam logic [11:0] IDX_CONFIG = 12'hec2;
  localparam logic [11:0] IDX_SUMMARY = 12'hec3;
  // field positions
  localparam int unsigned G5_BIT = 5;
  localparam int unsigned EV_B = 0;
  localparam int unsigned EV_C = 1;
  localparam int unsigned EV_E = 2;
  localparam int unsigned EV_G = 3;
  localparam int unsigned EV_W = 4;
  localparam int unsigned CFG_IE = 0;
  localparam int unsigned CFG_MCLR = 1;
  localparam int unsigned CFG_LVP = 2;
  localparam int unsigned CFG_W = 3;
  localparam int unsigned PIN_W = 25;
  // reset values
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic RST_G5_FLAG = 1'b0;
  localparam logic RST_G5_FALL = 1'b0;
  localparam logic RST_G5_RISE = 1'b1;
  localparam logic [3:0] RST_EV = 4'h0;
  localparam logic [2:0] RST_CFG = 3'h0;
  // pin bank, b in the top byte, g5 in bit 0
  typedef struct packed {
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] e;
    logic g5;
  } pcef_pins_t;
  // apb slave phases
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } pcef_apb_st_t;
endpackage

/* rtl/pcef_edge_detect.sv */
// edge detector for a bank of pin levels
// assumes levels already synchronous to core_clk_i
`timescale 1ns/10ps
module pcef_edge_detect #(
  parameter int unsigned W = 25
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // pin levels
  input wire logic [W-1:0] level_i,
  // one-cycle edge pulses
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] prev;
  logic primed;

  if (W == 0)
  begin
    $error("pcef_edge_detect needs at least one pin");
  end

  // previous level, first cycle after reset only loads it
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      prev <= '0;
      primed <= 1'b0;
    end
    else
    begin
      prev <= level_i;
      primed <= 1'b1;
    end
  end

  assign rise_o = primed ? (level_i & ~prev) : '0;
  assign fall_o = primed ? (~level_i & prev) : '0;
endmodule

/* rtl/pcef_flag_reg.sv */
// sticky flag bank, hardware sets, software clears by writing zero
// assumes wr_i is a one-cycle write strobe
`timescale 1ns/10ps
module pcef_flag_reg #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // hardware set and software write
  input wire logic [W-1:0] set_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  // flags
  output logic [W-1:0] flags_o
);
  if (W == 0)
  begin
    $error("pcef_flag_reg needs at least one flag");
  end

  // write can only clear, set beats clear
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      flags_o <= '0;
    else if (wr_i)
      flags_o <= (flags_o & wdata_i) | set_i;
    else
      flags_o <= flags_o | set_i;
  end
endmodule

/* verif/pcef_pin_model.sv */
// far-side pin driver for the pin change edge flag block
// assumes the bench sets wanted levels right after a rising clock edge
`timescale 1ns/10ps
module pcef_pin_model (
  // clock
  input wire logic core_clk_i,
  // wanted levels from the bench
  input wire pcef_pkg::pcef_pins_t level_i,
  // pin levels seen by the block
  output pcef_pkg::pcef_pins_t pins_o
);
  ////////////////////////////////////////////////////////////////////////
  // pins only move right after a clock edge, so they stay synchronous
  always @(posedge core_clk_i)
  begin
    pins_o <= level_i;
  end
endmodule

/* verif/pcef_top_bench.sv */
// self-checking bench for the pin change edge flag block
// assumes the pin model and the design files are compiled before it
`timescale 1ns/10ps
module pcef_top_bench;
  ////////////////////////////////////////////////////////////////////////
  // signals
  logic core_clk_i;
  logic sys_rst_i;
  logic psel;
  logic penable;
  logic pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic summary;
  pcef_pkg::pcef_pins_t want;
  pcef_pkg::pcef_pins_t pins;
  int errors;
  int samples_checked;
  logic [31:0] d;
  logic e;
  logic [11:0] flg [0:2];
  logic [11:0] fal [0:2];
  logic [11:0] ris [0:2];
  logic [11:0] all [0:15];
  ////////////////////////////////////////////////////////////////////////
  // design and far side
  pcef_top #(.ADDR_W(16)) i_pcef_top (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pins_i(pins),
    .irq_o(irq), .summary_o(summary)
  );
  pcef_pin_model i_pcef_pin_model (
    .core_clk_i(core_clk_i), .level_i(want), .pins_o(pins)
  );
  always #10 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic xfer(input logic wr, input logic [11:0] idx,
                      input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk_i);
    if (n >= 20)
    begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(d, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    core_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    want = '0;
    errors = 0;
    samples_checked = 0;
    flg = '{pcef_pkg::IDX_B_FLAG, pcef_pkg::IDX_C_FLAG, pcef_pkg::IDX_E_FLAG};
    fal = '{pcef_pkg::IDX_B_FALL, pcef_pkg::IDX_C_FALL, pcef_pkg::IDX_E_FALL};
    ris = '{pcef_pkg::IDX_B_RISE, pcef_pkg::IDX_C_RISE, pcef_pkg::IDX_E_RISE};
    all = '{12'he93, 12'he94, 12'he95, 12'he9b, 12'he9c, 12'he9d,
            12'hea8, 12'hea9, 12'heaa, 12'heb5, 12'heb6, 12'heb7,
            12'hec0, 12'hec1, 12'hec2, 12'hec3};
    cyc(16);
    sys_rst_i <= 1'b0;
    cyc(2);
    // reset values, g rise enable is the only one set
    for (int i = 0; i < 16; i++)
      rd_chk(all[i], (all[i] == pcef_pkg::IDX_G_RISE) ? 32'h20 : 32'h0);
    xfer(1'b0, 12'h000, 32'h0);
    check({31'h0, e}, 32'h1);
    // rising on low nibble, falling on high nibble
    for (int p = 0; p < 3; p++)
    begin
      xfer(1'b1, ris[p], 32'h0f);
      xfer(1'b1, fal[p], 32'hf0);
    end
    want <= '{b: 8'hff, c: 8'hff, e: 8'hff, g5: 1'b1};
    cyc(4);
    for (int p = 0; p < 3; p++)
      rd_chk(flg[p], 32'h0f);
    rd_chk(pcef_pkg::IDX_G_FLAG, 32'h20);
    check({31'h0, summary}, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd_chk(pcef_pkg::IDX_EV_STAT, 32'hf);
    rd_chk(pcef_pkg::IDX_SUMMARY, 32'h1);
    xfer(1'b1, pcef_pkg::IDX_EV_MASK, 32'hf);
    xfer(1'b1, pcef_pkg::IDX_CONFIG, 32'h1);
    cyc(3);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, pcef_pkg::IDX_EV_STAT, 32'hf);
    cyc(3);
    check({31'h0, irq}, 32'h0);
    // writing ones keeps, writing zero clears
    for (int p = 0; p < 3; p++)
    begin
      xfer(1'b1, flg[p], 32'hff);
      rd_chk(flg[p], 32'h0f);
      xfer(1'b1, flg[p], 32'hf0);
      rd_chk(flg[p], 32'h00);
    end
    xfer(1'b1, pcef_pkg::IDX_G_FLAG, 32'h0);
    rd_chk(pcef_pkg::IDX_G_FLAG, 32'h0);
    cyc(3);
    check({31'h0, summary}, 32'h0);
    // falling edges, g5 falling still disabled
    want <= '0;
    cyc(4);
    for (int p = 0; p < 3; p++)
      rd_chk(flg[p], 32'hf0);
    rd_chk(pcef_pkg::IDX_G_FLAG, 32'h0);
    check({31'h0, irq}, 32'h1);
    // g5 both directions, only bit five held
    xfer(1'b1, pcef_pkg::IDX_G_FALL, 32'hff);
    rd_chk(pcef_pkg::IDX_G_FALL, 32'h20);
    xfer(1'b1, pcef_pkg::IDX_G_FLAG, 32'hff);
    rd_chk(pcef_pkg::IDX_G_FLAG, 32'h0);
    want.g5 <= 1'b1;
    cyc(4);
    rd_chk(pcef_pkg::IDX_G_FLAG, 32'h20);
    xfer(1'b1, pcef_pkg::IDX_G_FLAG, 32'h0);
    want.g5 <= 1'b0;
    cyc(4);
    rd_chk(pcef_pkg::IDX_G_FLAG, 32'h20);
    // g5 unavailable with reset pin or low voltage programming
    xfer(1'b1, pcef_pkg::IDX_G_FLAG, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      xfer(1'b1, pcef_pkg::IDX_CONFIG, (k == 0) ? 32'h3 : 32'h5);
      want.g5 <= ~want.g5;
      cyc(4);
      rd_chk(pcef_pkg::IDX_G_FLAG, 32'h0);
    end
    // edge in the commit cycle of a clearing write survives it
    xfer(1'b1, pcef_pkg::IDX_B_RISE, 32'h01);
    fork
      xfer(1'b1, pcef_pkg::IDX_B_FLAG, 32'h00);
      begin
        cyc(2);
        want.b[0] <= 1'b1;
      end
    join
    rd_chk(pcef_pkg::IDX_B_FLAG, 32'h01);
    xfer(1'b1, pcef_pkg::IDX_B_FLAG, 32'h00);
    rd_chk(pcef_pkg::IDX_B_FLAG, 32'h00);
    // rising edge on a pin with rising detection off
    want.b[1] <= 1'b1;
    cyc(4);
    rd_chk(pcef_pkg::IDX_B_FLAG, 32'h00);
    // port c pin with both directions enabled
    xfer(1'b1, pcef_pkg::IDX_C_RISE, 32'hff);
    xfer(1'b1, pcef_pkg::IDX_C_FLAG, 32'h00);
    want.c[7] <= 1'b1;
    cyc(4);
    rd_chk(pcef_pkg::IDX_C_FLAG, 32'h80);
    give_verdict();
  end
endmodule
